// File: src/serial_port_slave.sv
// Serial port of the controller: slave receiver and bus condition monitor
// Behaviour
// - Matched address, no overflow: buffer, flag, acknowledge; write direction only
// - Buffer read clears buffer full flag
// - Write address match clears direction bit
// - Overflow withholds address acknowledge
// - Every data byte and matching write address sets interrupt flag regardless
// - Software clears the interrupt flag itself
// - Reset or disable clears start/stop flags
// - Latest start or stop flag wins
// - Firmware takes bus after stop or idle
// - Direction bits low pull lines low
// - Firmware sends bits by releasing or driving
// - Start, stop and bytes set interrupt flag; start and stop only with mode bit 3 set
// - Mode 1011 idles slave; software finds source
// - Enabling while busy interrupts at stop
// - Master releases lines on lost arbitration
// - Slave keeps receiving after lost arbitration
// - Data arbitration loss means later retry
// - Software keeps sample and edge bits clear
module serial_port_slave (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RST,
  // Processor register port
  input  wire logic [7:0] REG_ADDR,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic [7:0] REG_WDATA,
  output logic      [7:0] REG_RDATA,
  output logic            IRQ,
  // Two-wire bus
  two_wire_if.dev         BUS
);
  typedef enum logic [1:0] {S_IDLE, S_ADDR, S_DATA, S_ACK} rx_state_t;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  rx_state_t  st_q, st_d;
  logic [7:0] ctrl_q, dir_q, addr_q, buf_q, sr_q, rdata_q;
  logic [3:0] cnt_q;
  logic [1:0] stat_sw_q;
  logic       flag_q, ie_q, bf_q, rw_q, da_q, s_q, p_q, ack_q;
  logic       sda_s, scl_rise, scl_fall, start_p, stop_p;

  bus_condition_detect u_det (
    .clk      (CLK),
    .rst      (RST),
    .scl      (BUS.scl),
    .sda      (BUS.sda),
    .scl_s    (),
    .sda_s    (sda_s),
    .scl_rise (scl_rise),
    .scl_fall (scl_fall),
    .start_p  (start_p),
    .stop_p   (stop_p)
  );

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire enabled  = ctrl_q[two_wire_pkg::CTRL_EN];
  wire slave_on = enabled && (ctrl_q[3:0] != two_wire_pkg::MODE_FW_IDLE);
  wire cond_irq = enabled && ctrl_q[3];
  wire wr_flag  = REG_WR && hit(REG_ADDR, two_wire_pkg::OFF_IRQ_FLAGS);
  wire wr_en    = REG_WR && hit(REG_ADDR, two_wire_pkg::OFF_IRQ_EN);
  wire wr_buf   = REG_WR && hit(REG_ADDR, two_wire_pkg::OFF_DATA_BUF);
  wire wr_ctrl  = REG_WR && hit(REG_ADDR, two_wire_pkg::OFF_PORT_CTRL);
  wire wr_dir   = REG_WR && hit(REG_ADDR, two_wire_pkg::OFF_DIR_C);
  wire wr_addr  = REG_WR && hit(REG_ADDR, two_wire_pkg::OFF_OWN_ADDR);
  wire wr_stat  = REG_WR && hit(REG_ADDR, two_wire_pkg::OFF_PORT_STAT);
  wire rd_buf   = REG_RD && hit(REG_ADDR, two_wire_pkg::OFF_DATA_BUF);

  wire overflow   = bf_q | ctrl_q[two_wire_pkg::CTRL_OVF];
  wire addr_match = (sr_q[7:1] == addr_q[7:1]);
  wire receiving  = (st_q == S_ADDR) || (st_q == S_DATA);
  wire full_byte  = (cnt_q == two_wire_pkg::BITS_BYTE);
  wire byte_end   = scl_fall && receiving && full_byte;
  wire addr_end   = byte_end && (st_q == S_ADDR);
  wire data_end   = byte_end && (st_q == S_DATA);
  // Address byte with write direction for this device
  wire addr_write = addr_end && addr_match && !sr_q[0];
  wire take       = !overflow && (data_end || addr_write);
  wire ninth_end  = scl_fall && (st_q == S_ACK);
  wire cond_evt   = cond_irq && (start_p || stop_p);
  wire set_flag   = ninth_end || cond_evt;
  wire set_ovf    = data_end && bf_q;
  wire set_write_collision_flag   = wr_buf && (st_q != S_IDLE);

  // ---------------------------------------------------------------
  // Receive sequencer
  // ---------------------------------------------------------------
  // Own bus driving is not consulted, so a lost arbitration leaves
  // the receiver running and it still answers its own address.
  always_comb begin
    st_d = st_q;
    if (!slave_on) begin
      st_d = S_IDLE;
    end else if (start_p) begin
      st_d = S_ADDR;
    end else if (stop_p) begin
      st_d = S_IDLE;
    end else begin
      case (st_q)
        S_ADDR: begin
          if (addr_end) st_d = (addr_match && !sr_q[0]) ? S_ACK : S_IDLE;
        end
        S_DATA: begin
          if (data_end) st_d = S_ACK;
        end
        S_ACK: begin
          if (ninth_end) st_d = (ack_q || da_q) ? S_DATA : S_IDLE;
        end
        default: st_d = st_q;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st_q  <= S_IDLE;
      cnt_q <= 4'h0;
      sr_q  <= two_wire_pkg::RST_ZERO;
    end else begin
      st_q <= st_d;
      if (start_p || ninth_end) begin
        cnt_q <= 4'h0;
      end else if (scl_rise && receiving && !full_byte) begin
        cnt_q <= cnt_q + 4'h1;
        sr_q  <= {sr_q[6:0], sda_s};
      end
    end
  end

  // Acknowledge is held through the ninth clock low and high
  always_ff @(posedge CLK) begin
    if (RST) begin
      ack_q <= 1'b0;
    end else if (!slave_on || start_p || stop_p || ninth_end) begin
      ack_q <= 1'b0;
    end else if (byte_end) begin
      ack_q <= take;
    end
  end

  // ---------------------------------------------------------------
  // Status and buffer
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      buf_q <= two_wire_pkg::RST_ZERO;
      bf_q  <= 1'b0;
      rw_q  <= 1'b0;
      da_q  <= 1'b0;
    end else begin
      if (take) begin
        buf_q <= sr_q;
      end else if (wr_buf) begin
        buf_q <= REG_WDATA;
      end
      bf_q <= take | (bf_q & ~rd_buf);
      if (addr_end && addr_match) begin
        rw_q <= sr_q[0];
        da_q <= 1'b0;
      end else if (data_end) begin
        da_q <= 1'b1;
      end
    end
  end

  // Start and stop flags; reset and disable clear both
  always_ff @(posedge CLK) begin
    if (RST || !enabled) begin
      s_q <= 1'b0;
      p_q <= 1'b0;
    end else if (start_p) begin
      s_q <= 1'b1;
      p_q <= 1'b0;
    end else if (stop_p) begin
      s_q <= 1'b0;
      p_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  // Hardware sets win over a software clear in the same cycle
  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl_q    <= two_wire_pkg::RST_ZERO;
      dir_q     <= two_wire_pkg::RST_DIR;
      addr_q    <= two_wire_pkg::RST_ZERO;
      ie_q      <= 1'b0;
      flag_q    <= 1'b0;
      stat_sw_q <= 2'h0;
    end else begin
      if (wr_ctrl) ctrl_q <= REG_WDATA;
      if (set_ovf) ctrl_q[two_wire_pkg::CTRL_OVF] <= 1'b1;
      if (set_write_collision_flag) ctrl_q[two_wire_pkg::CTRL_WRITE_COLLISION_FLAG] <= 1'b1;
      if (wr_dir) dir_q <= REG_WDATA;
      if (wr_addr) addr_q <= REG_WDATA;
      if (wr_en) ie_q <= REG_WDATA[two_wire_pkg::BIT_SP_IRQ];
      if (wr_stat) stat_sw_q <= REG_WDATA[7:6];
      flag_q <= set_flag | (wr_flag ? REG_WDATA[two_wire_pkg::BIT_SP_IRQ] : flag_q);
    end
  end

  // ---------------------------------------------------------------
  // Read data, interrupt and pins
  // ---------------------------------------------------------------
  wire [7:0] flag_rd = {4'h0, flag_q, 3'h0};
  wire [7:0] ie_rd   = {4'h0, ie_q, 3'h0};
  wire [7:0] stat_rd = {stat_sw_q, da_q, p_q, s_q, rw_q, 1'b0, bf_q};
  wire [7:0] rd_val  =
    hit(REG_ADDR, two_wire_pkg::OFF_IRQ_FLAGS) ? flag_rd :
    hit(REG_ADDR, two_wire_pkg::OFF_IRQ_EN)    ? ie_rd   :
    hit(REG_ADDR, two_wire_pkg::OFF_DATA_BUF)  ? buf_q   :
    hit(REG_ADDR, two_wire_pkg::OFF_PORT_CTRL) ? ctrl_q  :
    hit(REG_ADDR, two_wire_pkg::OFF_DIR_C)     ? dir_q   :
    hit(REG_ADDR, two_wire_pkg::OFF_OWN_ADDR)  ? addr_q  :
    hit(REG_ADDR, two_wire_pkg::OFF_PORT_STAT) ? stat_rd : 8'h00;

  always_ff @(posedge CLK) begin
    if (RST) begin
      rdata_q <= two_wire_pkg::RST_ZERO;
    end else if (REG_RD) begin
      rdata_q <= rd_val;
    end
  end

  assign REG_RDATA = rdata_q;
  assign IRQ       = flag_q & ie_q;
  // Pins only ever pull low; the output latch is never used
  assign BUS.dev_scl_oe = ~dir_q[two_wire_pkg::DIR_SCL];
  assign BUS.dev_sda_oe = ~dir_q[two_wire_pkg::DIR_SDA] | ack_q;
endmodule // serial_port_slave

// File: src/two_wire_pkg.sv
// Shared constants for the two-wire serial port and its bus master
package two_wire_pkg;
  // ---------------------------------------------------------------
  // Device register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_IRQ_FLAGS = 8'h0c;
  localparam logic [7:0] OFF_DATA_BUF  = 8'h13;
  localparam logic [7:0] OFF_PORT_CTRL = 8'h14;
  localparam logic [7:0] OFF_DIR_C     = 8'h87;
  localparam logic [7:0] OFF_IRQ_EN    = 8'h8c;
  localparam logic [7:0] OFF_OWN_ADDR  = 8'h93;
  localparam logic [7:0] OFF_PORT_STAT = 8'h94;
  // ---------------------------------------------------------------
  // Device field positions and reset values
  // ---------------------------------------------------------------
  localparam int         BIT_SP_IRQ   = 3;
  localparam int         CTRL_WRITE_COLLISION_FLAG    = 7;
  localparam int         CTRL_OVF     = 6;
  localparam int         CTRL_EN      = 5;
  localparam int         DIR_SCL      = 3;
  localparam int         DIR_SDA      = 4;
  localparam logic [3:0] MODE_FW_IDLE = 4'hb;
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [7:0] RST_DIR      = 8'hff;
  localparam logic [3:0] BITS_BYTE    = 4'h8;
  // ---------------------------------------------------------------
  // Master register offsets and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] H_OFF_CMD  = 8'h00;
  localparam logic [7:0] H_OFF_STAT = 8'h04;
  localparam logic [7:0] H_OFF_MASK = 8'h08;
  localparam int         HS_DONE    = 0;
  localparam int         HS_NACK    = 1;
  localparam int         HS_LOST    = 2;
  localparam int         HS_BUSY    = 4;
  localparam int         HS_ACTIVE  = 5;
  localparam int         CMD_START  = 8;
  localparam int         CMD_STOP   = 9;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int         CLK_NS        = 50;
  localparam int         SCL_PERIOD_NS = 2000;
  localparam logic [3:0] QTR_CYC = 4'(SCL_PERIOD_NS / (4 * CLK_NS));
endpackage

// File: src/two_wire_if.sv
// Open-drain two-wire bus joining the serial port and the master
interface two_wire_if;
  logic dev_scl_oe;
  logic dev_sda_oe;
  logic host_scl_oe;
  logic host_sda_oe;
  logic scl;
  logic sda;
  // Pull-ups make the lines high unless someone pulls low
  assign scl = ~(dev_scl_oe | host_scl_oe);
  assign sda = ~(dev_sda_oe | host_sda_oe);
  modport dev  (input scl, input sda, output dev_scl_oe, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_oe, output host_sda_oe);
endinterface

// File: src/bus_condition_detect.sv
// Line synchronisers with clock edge and start/stop detection
module bus_condition_detect (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Raw lines
  input  wire logic scl,
  input  wire logic sda,
  // Synchronised view
  output logic      scl_s,
  output logic      sda_s,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_p,
  output logic      stop_p
);
  logic [1:0] scl_m_q, sda_m_q;
  logic       scl_q, sda_q, scl_o_q, sda_o_q;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_m_q <= 2'h3;
      sda_m_q <= 2'h3;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      scl_o_q <= 1'b1;
      sda_o_q <= 1'b1;
    end else begin
      scl_m_q <= {scl_m_q[0], scl};
      sda_m_q <= {sda_m_q[0], sda};
      scl_q   <= scl_m_q[1];
      sda_q   <= sda_m_q[1];
      scl_o_q <= scl_q;
      sda_o_q <= sda_q;
    end
  end

  assign scl_s    = scl_q;
  assign sda_s    = sda_q;
  assign scl_rise = scl_q & ~scl_o_q;
  assign scl_fall = ~scl_q & scl_o_q;
  assign start_p  = scl_q & scl_o_q & sda_o_q & ~sda_q;
  assign stop_p   = scl_q & scl_o_q & ~sda_o_q & sda_q;
endmodule // bus_condition_detect

// File: src/two_wire_master.sv
// Bus master on the far side, commanded over APB
module two_wire_master (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             IRQ,
  // Two-wire bus
  two_wire_if.host         BUS
);
  typedef enum logic [2:0] {H_IDLE, H_WAIT, H_START, H_BIT, H_STOP} m_state_t;

  m_state_t   st_q;
  logic [7:0] tx_q;
  logic [3:0] bit_q, qcnt_q;
  logic [1:0] ph_q;
  logic [2:0] sts_q, mask_q;
  logic [31:0] rdata_q;
  logic       scl_oe_q, sda_oe_q, start_q, stop_q, busy_q;
  logic       scl_s, sda_s, start_p, stop_p;

  bus_condition_detect u_det (
    .clk      (CLK),
    .rst      (RST),
    .scl      (BUS.scl),
    .sda      (BUS.sda),
    .scl_s    (scl_s),
    .sda_s    (sda_s),
    .scl_rise (),
    .scl_fall (),
    .start_p  (start_p),
    .stop_p   (stop_p)
  );

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  wire access   = PSEL && PENABLE;
  wire setup_rd = PSEL && !PENABLE && !PWRITE;
  wire known    = (PADDR == two_wire_pkg::H_OFF_CMD) || (PADDR == two_wire_pkg::H_OFF_STAT) ||
                  (PADDR == two_wire_pkg::H_OFF_MASK);
  wire launch   = access && PWRITE && (PADDR == two_wire_pkg::H_OFF_CMD) && (st_q == H_IDLE);
  wire rd_stat  = access && !PWRITE && (PADDR == two_wire_pkg::H_OFF_STAT);
  wire wr_mask  = access && PWRITE && (PADDR == two_wire_pkg::H_OFF_MASK);
  wire [31:0] stat_rd = {26'h0, st_q != H_IDLE, busy_q, 1'b0, sts_q};
  wire [31:0] rd_val  = (PADDR == two_wire_pkg::H_OFF_STAT) ? stat_rd :
                        (PADDR == two_wire_pkg::H_OFF_MASK) ? {29'h0, mask_q} : 32'h0;

  // ---------------------------------------------------------------
  // Quarter-period timing
  // ---------------------------------------------------------------
  // A slave holding the clock low stalls the high-phase quarter
  wire stretch = (st_q == H_BIT) && (ph_q == 2'h2) && !scl_s;
  wire tick    = (qcnt_q == 4'h0) && !stretch;
  wire last    = (bit_q == two_wire_pkg::BITS_BYTE);
  wire lost    = (st_q == H_BIT) && tick && (ph_q == 2'h2) && !last && !sda_oe_q && !sda_s;
  wire done    = (st_q == H_BIT) && tick && (ph_q == 2'h3) && last;
  wire nack    = (st_q == H_BIT) && tick && (ph_q == 2'h2) && last && sda_s;
  wire [2:0] evt = {lost, nack, done};

  always_ff @(posedge CLK) begin
    if (RST || st_q == H_IDLE || st_q == H_WAIT || tick) begin
      qcnt_q <= two_wire_pkg::QTR_CYC - 4'h1;
    end else if (qcnt_q != 4'h0) begin
      qcnt_q <= qcnt_q - 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      st_q     <= H_IDLE;
      ph_q     <= 2'h0;
      bit_q    <= 4'h0;
      tx_q     <= 8'h00;
      start_q  <= 1'b0;
      stop_q   <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      case (st_q)
        H_IDLE: begin
          if (launch) begin
            st_q    <= H_WAIT;
            tx_q    <= PWDATA[7:0];
            start_q <= PWDATA[two_wire_pkg::CMD_START];
            stop_q  <= PWDATA[two_wire_pkg::CMD_STOP];
          end
        end
        H_WAIT: begin
          ph_q  <= 2'h0;
          bit_q <= 4'h0;
          if (!start_q) st_q <= H_BIT;
          else if (!busy_q || scl_oe_q) st_q <= H_START;
        end
        H_START: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              2'h0: sda_oe_q <= 1'b0;
              2'h1: scl_oe_q <= 1'b0;
              2'h2: sda_oe_q <= 1'b1;
              default: begin
                scl_oe_q <= 1'b1;
                st_q     <= H_BIT;
              end
            endcase
          end
        end
        H_BIT: begin
          if (lost) begin
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            st_q     <= H_IDLE;
          end else if (tick) begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              2'h0: sda_oe_q <= last ? 1'b0 : ~tx_q[7];
              2'h1: scl_oe_q <= 1'b0;
              2'h2: scl_oe_q <= 1'b0;
              default: begin
                scl_oe_q <= 1'b1;
                tx_q     <= {tx_q[6:0], 1'b0};
                bit_q    <= bit_q + 4'h1;
                if (last) st_q <= stop_q ? H_STOP : H_IDLE;
              end
            endcase
          end
        end
        H_STOP: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              2'h0: sda_oe_q <= 1'b1;
              2'h1: scl_oe_q <= 1'b0;
              default: begin
                sda_oe_q <= 1'b0;
                st_q     <= H_IDLE;
              end
            endcase
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Bus busy, status, interrupt, APB data
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      busy_q  <= 1'b0;
      sts_q   <= 3'h0;
      mask_q  <= 3'h0;
      rdata_q <= 32'h0;
    end else begin
      if (start_p) busy_q <= 1'b1;
      else if (stop_p) busy_q <= 1'b0;
      sts_q <= evt | (rd_stat ? 3'h0 : sts_q);
      if (wr_mask) mask_q <= PWDATA[2:0];
      if (setup_rd) rdata_q <= rd_val;
    end
  end

  assign PRDATA          = rdata_q;
  assign PREADY          = 1'b1;
  assign PSLVERR         = access && !known;
  assign IRQ             = |(sts_q & mask_q);
  assign BUS.host_scl_oe = scl_oe_q;
  assign BUS.host_sda_oe = sda_oe_q;
endmodule // two_wire_master

// File: verif/i2c_slave_bus_monitor_sva.sv
// Concurrent checks on the two-wire bus joining serial port and master
module i2c_slave_bus_monitor_sva (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Bus enables and levels
  input wire logic dev_scl_oe,
  input wire logic dev_sda_oe,
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // ---------------------------------------------------------------
  // Acknowledge timing; firmware pulls (scl also driven) are exempt
  // ---------------------------------------------------------------
  a_ack_scl_low: assert property ($rose(dev_sda_oe) && !dev_scl_oe |-> !scl)
    else $error("acknowledge started while clock high");
  // A firmware release of both lines at once is not an acknowledge
  a_ack_release_low: assert property ($fell(dev_sda_oe) && !$past(dev_scl_oe) |-> !scl)
    else $error("acknowledge released while clock high");
  a_ack_steady_high: assert property (dev_sda_oe && scl |=> dev_sda_oe)
    else $error("acknowledge dropped during clock high");
  a_ack_one_bit: assert property ($rose(dev_sda_oe) && !dev_scl_oe |-> ##[1:80] !dev_sda_oe)
    else $error("acknowledge held too long");
  // ---------------------------------------------------------------
  // Wire levels and bus conditions
  // ---------------------------------------------------------------
  // Data needs the clock held low at least nine cycles before it rises
  a_clock_low_hold: assert property ($rose(host_scl_oe) |=> host_scl_oe [*8])
    else $error("clock low phase too short");
  a_ack_host_free: assert property (dev_sda_oe && !dev_scl_oe && scl |-> !host_sda_oe)
    else $error("master drove data during acknowledge");
  a_reset_released: assert property ($fell(RST) |-> !(dev_scl_oe || dev_sda_oe || host_scl_oe || host_sda_oe))
    else $error("line pulled low out of reset");
  a_start_by_host: assert property ($fell(sda) && $past(scl) && scl |-> host_sda_oe)
    else $error("start made by the serial port");
endmodule // i2c_slave_bus_monitor_sva

// File: verif/i2c_slave_bus_monitor_tb.sv
// Self-checking bench: serial port slave and two-wire master back to back
module i2c_slave_bus_monitor_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk, rst, reg_wr, reg_rd, irq_d, psel, penable, pwrite, pready, pslverr, irq_m;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, paddr, q, adr, dat, perr;
  logic [31:0] pwdata, prdata, pq, seed;
  logic [7:0] offs [7] = '{8'h0c, 8'h14, 8'h8c, 8'h93, 8'h94, 8'h87, 8'h50};
  logic [7:0] rsts [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00};
  int         error_cnt, n_tests;
  two_wire_if bus ();
  serial_port_slave serial_port_slave_inst (.CLK(clk), .RST(rst), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .IRQ(irq_d), .BUS(bus.dev));
  two_wire_master two_wire_master_inst (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq_m),
    .BUS(bus.host));
  i2c_slave_bus_monitor_sva i2c_slave_bus_monitor_sva_inst (.CLK(clk), .RST(rst), .dev_scl_oe(bus.dev_scl_oe),
    .dev_sda_oe(bus.dev_sda_oe), .host_scl_oe(bus.host_scl_oe), .host_sda_oe(bus.host_sda_oe), .scl(bus.scl),
    .sda(bus.sda));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] nx(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [7:0] st(input logic p, input logic s, input logic f);
    return {3'b000, p, s, 2'b00, f};
  endfunction
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      $display("unexpected at %0t: expected %h got %h", $time, e, g);
      error_cnt++;
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic dev(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clk);
    q = reg_rdata;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    pq = prdata;
    perr = {7'h0, pslverr};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Waits out the stop too, which follows the done event by about a bit
  task automatic xfer(input logic [9:0] cmd, input logic nack);
    apb(1'b1, two_wire_pkg::H_OFF_CMD, {22'h0, cmd});
    while (irq_m !== 1'b1) @(posedge clk);
    repeat (8 * two_wire_pkg::QTR_CYC) @(posedge clk);
    apb(1'b0, two_wire_pkg::H_OFF_STAT, 32'h0);
    chk({7'h0, nack}, {7'h0, pq[two_wire_pkg::HS_NACK]});
    repeat (2) @(posedge clk);
    chk(8'h00, {7'h0, irq_m});
  endtask
  // ---------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
  initial begin
    {rst, reg_wr, reg_rd, psel, penable, pwrite} = 6'b100000;
    {reg_addr, reg_wdata, paddr, pwdata} = 56'h0;
    seed = 32'd96;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    foreach (offs[i]) begin
      dev(1'b0, offs[i], 8'h00);
      chk(rsts[i], q);
    end
    apb(1'b0, 8'h0c, 32'h0);
    chk(8'h01, perr);
    apb(1'b1, two_wire_pkg::H_OFF_MASK, 32'h1);
    seed = nx(seed);
    adr = {seed[6:0], 1'b0};
    dev(1'b1, 8'h93, adr);
    dev(1'b1, 8'h8c, 8'h08);
    dev(1'b1, 8'h14, 8'h26);
    for (int i = 0; i < 2; i++) begin
      seed = nx(seed);
      dat = seed[15:8];
      xfer({2'b01, adr}, 1'b0);
      chk(8'h10, pq[7:0] & 8'h30);
      dev(1'b0, 8'h94, 8'h00);
      chk(st(1'b0, 1'b1, 1'b1), q & 8'h1d);
      chk(8'h01, {7'h0, irq_d});
      dev(1'b0, 8'h13, 8'h00);
      chk(adr, q);
      dev(1'b0, 8'h94, 8'h00);
      chk(8'h00, q & 8'h01);
      dev(1'b1, 8'h0c, 8'h00);
      xfer({2'b10, dat}, 1'b0);
      chk(8'h00, pq[7:0] & 8'h30);
      dev(1'b0, 8'h0c, 8'h00);
      chk(8'h08, q & 8'h08);
      dev(1'b0, 8'h13, 8'h00);
      chk(dat, q);
      dev(1'b0, 8'h94, 8'h00);
      chk(st(1'b1, 1'b0, 1'b0), q & 8'h1d);
      dev(1'b1, 8'h0c, 8'h00);
    end
    dev(1'b1, 8'h14, 8'h00);
    dev(1'b0, 8'h94, 8'h00);
    chk(8'h00, q & 8'h18);
    dev(1'b1, 8'h14, 8'h26);
    xfer({2'b01, adr}, 1'b0);
    dev(1'b1, 8'h0c, 8'h00);
    xfer({2'b10, ~dat}, 1'b1);
    dev(1'b0, 8'h0c, 8'h00);
    chk(8'h08, q & 8'h08);
    dev(1'b0, 8'h14, 8'h00);
    chk(8'h66, q);
    xfer({2'b11, adr}, 1'b1);
    dev(1'b0, 8'h13, 8'h00);
    chk(adr, q);
    dev(1'b1, 8'h14, 8'h26);
    xfer({2'b11, adr ^ 8'h02}, 1'b1);
    xfer({2'b11, adr | 8'h01}, 1'b1);
    dev(1'b0, 8'h94, 8'h00);
    chk(8'h04, q & 8'h05);
    dev(1'b1, 8'h87, 8'he7);
    chk(8'h00, {6'h0, bus.scl, bus.sda});
    dev(1'b1, 8'h87, 8'hff);
    chk(8'h03, {6'h0, bus.scl, bus.sda});
    // Slave idle, start/stop events only; interrupt first masked
    dev(1'b1, 8'h8c, 8'h00);
    dev(1'b1, 8'h14, 8'h2b);
    dev(1'b1, 8'h0c, 8'h00);
    xfer({2'b01, adr}, 1'b1);
    dev(1'b0, 8'h0c, 8'h00);
    chk(8'h08, q & 8'h08);
    chk(8'h00, {7'h0, irq_d});
    dev(1'b1, 8'h0c, 8'h00);
    dev(1'b1, 8'h8c, 8'h08);
    chk(8'h00, {7'h0, irq_d});
    xfer({2'b10, dat}, 1'b1);
    chk(8'h01, {7'h0, irq_d});
    end_sim();
  end
endmodule // i2c_slave_bus_monitor_tb
